// ===== hw/espil_link.sv
// Link initiator top: request handling, straps, side services
`timescale 1ns/100ps
module espil_link (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic link_clk,
  input wire logic strap_en_pin,
  input espil_pkg::espil_strap_t strap,
  input wire logic [7:0] wait_limit,
  input wire logic req_valid,
  input espil_pkg::espil_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output espil_pkg::espil_rsp_t rsp,
  output espil_pkg::espil_chan_t rsp_chan,
  output logic rsp_pm_valid,
  output logic rsp_se_valid,
  input wire logic rsp_crc_bad,
  output logic sleep,
  output logic [1:0] initiator_flash_sharing,
  output logic peci_pin_en,
  output logic peci_link_en,
  input wire logic peci_req,
  input wire logic low_power_idle_state,
  input wire logic cpu_data_valid,
  output logic cpu_wake,
  output logic peci_rsp_ok,
  input wire logic rtc_req,
  input wire logic [63:0] rtc_now,
  output logic rtc_tx_valid,
  output logic [63:0] rtc_tx_data,
  output logic espi_cs_n,
  output logic espi_sck,
  output logic [3:0] espi_io_o,
  output logic [3:0] espi_io_oe_n,
  input wire logic [3:0] espi_io_i
);
  import espil_pkg::*;
  espil_top_st_t st_ff, nxt_st;
  espil_frame_t fr_ff, nxt_fr;
  espil_rsp_t rsp_ff, nxt_rsp, eng_rsp;
  espil_chan_t chan_ff, nxt_chan;
  espil_width_t width_ff, nxt_width;
  logic [1:0] freq_ff, nxt_freq, flash_ff, nxt_flash;
  logic [63:0] rtc_ff, nxt_rtc;
  logic [3:0] io_q;
  logic se_ff, nxt_se, cfg_ff, nxt_cfg, is_rst_ff, nxt_is_rst;
  logic last_cfg_ff, nxt_last_cfg, rst_pend_ff, nxt_rst_pend;
  logic ready_ff, nxt_ready, rv_ff, nxt_rv, pm_ff, nxt_pm, sev_ff, nxt_sev;
  logic sleep_ff, nxt_sleep, pin_ff, nxt_pin, plink_ff, nxt_plink;
  logic ppend_ff, nxt_ppend, wake_ff, nxt_wake, pok_ff, nxt_pok;
  logic rtcv_ff, nxt_rtcv, tgl_ff, nxt_tgl, dseen_ff, run_ff;
  logic en_q, done_q, run_q, req_q, sseen_ff, eng_tgl, launch, launch_rst, done_ev;

  // Strap pin and completion toggle cross into this domain; run, request toggle and data lines cross into link_clk
  espil_sync #(.W(1)) u_en_sync (
    .clk(clock),
    .rst(sys_rst),
    .d(strap_en_pin),
    .q(en_q)
  );
  espil_sync #(.W(1)) u_done_sync (
    .clk(clock),
    .rst(sys_rst),
    .d(eng_tgl),
    .q(done_q)
  );
  espil_sync #(.W(1)) u_run_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d(run_ff),
    .q(run_q)
  );
  espil_sync #(.W(1)) u_req_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d(tgl_ff),
    .q(req_q)
  );
  espil_sync #(.W(4)) u_io_sync (
    .clk(link_clk),
    .rst(sys_rst),
    .d(espi_io_i),
    .q(io_q)
  );

  // Frame stays stable in fr_ff until the engine reports done
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst) sseen_ff <= 1'b0;
    else if (run_q) sseen_ff <= req_q;
  end

  espil_ser u_ser (
    .link_clk(link_clk),
    .sys_rst(sys_rst),
    .run(run_q),
    .start(req_q != sseen_ff),
    .frame(fr_ff),
    .done_tgl(eng_tgl),
    .rsp(eng_rsp),
    .cs_n(espi_cs_n),
    .sck(espi_sck),
    .io_o(espi_io_o),
    .io_oe_n(espi_io_oe_n),
    .io_i(io_q)
  );

  // Run follows the strap only while clk_en is high, so the link freezes too
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst) run_ff <= 1'b0;
    else run_ff <= en_q && clk_en;
  end

  always_comb
  begin
    done_ev = (done_q != dseen_ff);
    launch = (st_ff == ESPIL_TS_IDLE) && !sleep_ff && (rst_pend_ff || (req_valid && ready_ff));
    launch_rst = launch && rst_pend_ff;
    nxt_st = st_ff;
    nxt_fr = fr_ff;
    nxt_rsp = rsp_ff;
    nxt_chan = chan_ff;
    nxt_se = se_ff;
    nxt_cfg = cfg_ff;
    nxt_is_rst = is_rst_ff;
    nxt_last_cfg = last_cfg_ff;
    nxt_width = width_ff;
    nxt_freq = freq_ff;
    nxt_tgl = tgl_ff;
    nxt_rv = 1'b0;
    nxt_pm = 1'b0;
    nxt_sev = 1'b0;
    nxt_sleep = !en_q;
    nxt_ready = (nxt_st == ESPIL_TS_IDLE) && !nxt_sleep;
    nxt_flash = strap.flash_share;
    nxt_pin = !strap.peci_over_link;
    nxt_plink = strap.peci_over_link;
    nxt_rst_pend = (rst_pend_ff && !launch_rst) || (rsp_crc_bad && last_cfg_ff);
    if (launch)
    begin
      nxt_tgl = !tgl_ff;
      nxt_st = ESPIL_TS_BUSY;
      nxt_ready = 1'b0;
      nxt_fr.wait_lim = wait_limit;
      if (launch_rst)
      begin
        nxt_fr.tx_data = {CMD_INBAND_RST, 56'h0};
        nxt_fr.tx_last = 3'h0;
        nxt_fr.rx_last = 3'h0;
        nxt_fr.width = ESPIL_W1;
        nxt_fr.half = HALF_F20;
        nxt_is_rst = 1'b1;
        nxt_cfg = 1'b0;
        nxt_width = ESPIL_W1;
        nxt_freq = FREQ_F20;
      end
      else
      begin
        nxt_fr.tx_data = req.tx_data;
        nxt_fr.tx_last = req.tx_last;
        nxt_fr.rx_last = req.rx_last;
        nxt_fr.width = width_ff;
        case (freq_ff)
          FREQ_F25: nxt_fr.half = HALF_F25;
          FREQ_F33: nxt_fr.half = HALF_F33;
          FREQ_F50: nxt_fr.half = HALF_F50;
          default: nxt_fr.half = HALF_F20;
        endcase
        nxt_chan = req.chan;
        nxt_se = req.oob_se;
        nxt_cfg = req.set_cfg;
        nxt_is_rst = 1'b0;
      end
    end
    else if (st_ff == ESPIL_TS_BUSY && done_ev)
    begin
      nxt_st = ESPIL_TS_IDLE;
      nxt_ready = !nxt_sleep && !nxt_rst_pend;
      if (!is_rst_ff)
      begin
        nxt_rsp = eng_rsp;
        nxt_rv = 1'b1;
        nxt_pm = (chan_ff == ESPIL_CH_OOB) && !se_ff;
        nxt_sev = (chan_ff == ESPIL_CH_OOB) && se_ff;
        nxt_last_cfg = cfg_ff;
        if (cfg_ff && !eng_rsp.wait_err)
        begin
          nxt_width = strap.max_width;
          nxt_freq = strap.freq_sel;
        end
      end
    end
    if (nxt_rst_pend) nxt_ready = 1'b0;
  end

  always_comb
  begin
    nxt_ppend = ppend_ff;
    nxt_pok = 1'b0;
    if (peci_req && plink_ff && !sleep_ff) nxt_ppend = 1'b1;
    else if (ppend_ff && cpu_data_valid)
    begin
      nxt_ppend = 1'b0;
      nxt_pok = 1'b1;
    end
    nxt_wake = nxt_ppend && low_power_idle_state;
    nxt_rtcv = rtc_req && !sleep_ff;
    nxt_rtc = nxt_rtcv ? rtc_now : rtc_ff;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= ESPIL_TS_IDLE;
      fr_ff <= '0;
      rsp_ff <= '0;
      chan_ff <= ESPIL_CH_PERIPH;
      se_ff <= 1'b0;
      cfg_ff <= 1'b0;
      is_rst_ff <= 1'b0;
      last_cfg_ff <= 1'b0;
      width_ff <= ESPIL_W1;
      freq_ff <= FREQ_F20;
      tgl_ff <= 1'b0;
      dseen_ff <= 1'b0;
      rv_ff <= 1'b0;
      pm_ff <= 1'b0;
      sev_ff <= 1'b0;
      ready_ff <= 1'b0;
      sleep_ff <= 1'b1;
      flash_ff <= FLASH_SHARE_RST;
      pin_ff <= 1'b1;
      plink_ff <= 1'b0;
      rst_pend_ff <= 1'b0;
      ppend_ff <= 1'b0;
      wake_ff <= 1'b0;
      pok_ff <= 1'b0;
      rtcv_ff <= 1'b0;
      rtc_ff <= 64'h0;
    end
    else if (clk_en)
    begin
      st_ff <= nxt_st;
      fr_ff <= nxt_fr;
      rsp_ff <= nxt_rsp;
      chan_ff <= nxt_chan;
      se_ff <= nxt_se;
      cfg_ff <= nxt_cfg;
      is_rst_ff <= nxt_is_rst;
      last_cfg_ff <= nxt_last_cfg;
      width_ff <= nxt_width;
      freq_ff <= nxt_freq;
      tgl_ff <= nxt_tgl;
      dseen_ff <= done_q;
      rv_ff <= nxt_rv;
      pm_ff <= nxt_pm;
      sev_ff <= nxt_sev;
      ready_ff <= nxt_ready;
      sleep_ff <= nxt_sleep;
      flash_ff <= nxt_flash;
      pin_ff <= nxt_pin;
      plink_ff <= nxt_plink;
      rst_pend_ff <= nxt_rst_pend;
      ppend_ff <= nxt_ppend;
      wake_ff <= nxt_wake;
      pok_ff <= nxt_pok;
      rtcv_ff <= nxt_rtcv;
      rtc_ff <= nxt_rtc;
    end
  end

  assign req_ready = ready_ff;
  assign rsp_valid = rv_ff;
  assign rsp = rsp_ff;
  assign rsp_chan = chan_ff;
  assign rsp_pm_valid = pm_ff;
  assign rsp_se_valid = sev_ff;
  assign sleep = sleep_ff;
  assign initiator_flash_sharing = flash_ff;
  assign peci_pin_en = pin_ff;
  assign peci_link_en = plink_ff;
  assign cpu_wake = wake_ff;
  assign peci_rsp_ok = pok_ff;
  assign rtc_tx_valid = rtcv_ff;
  assign rtc_tx_data = rtc_ff;

  AST_PECI_ONE_PATH: assert property (@(posedge clock) disable iff (sys_rst)
    pin_ff != plink_ff) else $error("Both control paths enabled");
  AST_SLEEP_NO_REQ: assert property (@(posedge clock) disable iff (sys_rst)
    sleep_ff |-> !ready_ff && !launch) else $error("Request taken while asleep");
  AST_RST_DEFAULTS: assert property (@(posedge clock) disable iff (sys_rst)
    (launch_rst && clk_en) |=> (width_ff == ESPIL_W1 && freq_ff == FREQ_F20 && is_rst_ff))
    else $error("Reset did not restore defaults");
  AST_RTC_SEND: assert property (@(posedge clock) disable iff (sys_rst)
    (rtc_req && clk_en && !sleep_ff) |=> (rtcv_ff && rtc_ff == $past(rtc_now)))
    else $error("Time not sent on request");
  AST_PECI_ANSWER: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(pok_ff) |-> $past(cpu_data_valid) && $past(ppend_ff))
    else $error("Answer before processor data");
  AST_OOB_SPLIT: assert property (@(posedge clock) disable iff (sys_rst)
    (pm_ff || sev_ff) |-> (rv_ff && chan_ff == ESPIL_CH_OOB && (sev_ff == se_ff) && !(pm_ff && sev_ff)))
    else $error("Out-of-band answer misrouted");
endmodule // espil_link

// ===== hw/espil_pkg.sv
// Shared constants and types for the link initiator
package espil_pkg;
  localparam int REF_MHZ = 200;
  localparam int F20_MHZ = 20;
  localparam int F25_MHZ = 25;
  localparam int F33_MHZ = 33;
  localparam int F50_MHZ = 50;
  localparam logic [3:0] HALF_F20 = 4'(REF_MHZ / (2 * F20_MHZ));
  localparam logic [3:0] HALF_F25 = 4'(REF_MHZ / (2 * F25_MHZ));
  localparam logic [3:0] HALF_F33 = 4'(REF_MHZ / (2 * F33_MHZ));
  localparam logic [3:0] HALF_F50 = 4'(REF_MHZ / (2 * F50_MHZ));
  localparam logic [1:0] FREQ_F20 = 2'h0;
  localparam logic [1:0] FREQ_F25 = 2'h1;
  localparam logic [1:0] FREQ_F33 = 2'h2;
  localparam logic [1:0] FREQ_F50 = 2'h3;
  localparam logic [7:0] CMD_INBAND_RST = 8'hff;
  localparam logic [7:0] RSP_WAIT = 8'h0f;
  localparam logic [1:0] TAR_CYC = 2'h2;
  localparam logic [3:0] OE_N_W1 = 4'he;
  localparam logic [3:0] OE_N_W2 = 4'hc;
  localparam logic [3:0] OE_N_W4 = 4'h0;
  localparam logic [3:0] OE_N_OFF = 4'hf;
  localparam logic [1:0] FLASH_SHARE_RST = 2'h0;

  typedef enum logic [1:0] {
    ESPIL_CH_PERIPH = 2'b00,
    ESPIL_CH_VWIRE = 2'b01,
    ESPIL_CH_OOB = 2'b10,
    ESPIL_CH_FLASH = 2'b11
  } espil_chan_t;
  typedef enum logic [1:0] {
    ESPIL_W1 = 2'b00,
    ESPIL_W2 = 2'b01,
    ESPIL_W4 = 2'b10
  } espil_width_t;
  typedef enum logic [2:0] {
    ESPIL_IDLE = 3'b000,
    ESPIL_CMD = 3'b001,
    ESPIL_TAR = 3'b010,
    ESPIL_RSP = 3'b011,
    ESPIL_END = 3'b100
  } espil_st_t;
  typedef enum logic [1:0] {
    ESPIL_TS_IDLE = 2'b00,
    ESPIL_TS_BUSY = 2'b01
  } espil_top_st_t;
  typedef struct packed {
    espil_chan_t chan;
    logic oob_se;
    logic set_cfg;
    logic [2:0] tx_last;
    logic [2:0] rx_last;
    logic [63:0] tx_data;
  } espil_req_t;
  typedef struct packed {
    espil_width_t width;
    logic [3:0] half;
    logic [2:0] tx_last;
    logic [2:0] rx_last;
    logic [7:0] wait_lim;
    logic [63:0] tx_data;
  } espil_frame_t;
  typedef struct packed {
    logic [63:0] rx_data;
    logic wait_err;
  } espil_rsp_t;
  typedef struct packed {
    logic [1:0] freq_sel;
    logic [1:0] flash_share;
    logic peci_over_link;
    espil_width_t max_width;
  } espil_strap_t;
endpackage

// ===== hw/espil_sync.sv
// Two-stage synchroniser for levels and toggles
`timescale 1ns/100ps
module espil_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end
  assign q = q_ff;
endmodule // espil_sync

// ===== hw/espil_ser.sv
// Serial engine on the link reference clock
`timescale 1ns/100ps
module espil_ser (
  input wire logic link_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic start,
  input espil_pkg::espil_frame_t frame,
  output logic done_tgl,
  output espil_pkg::espil_rsp_t rsp,
  output logic cs_n,
  output logic sck,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_n,
  input wire logic [3:0] io_i
);
  import espil_pkg::*;
  espil_st_t st_ff, nxt_st;
  espil_frame_t fr_ff, nxt_fr;
  logic [63:0] sh_ff, nxt_sh, rx_ff, nxt_rx;
  logic [7:0] rxb_ff, nxt_rxb, wait_ff, nxt_wait;
  logic [3:0] half_ff, nxt_half, io_ff, nxt_io, oe_ff, nxt_oe, bpc;
  logic [2:0] bit_ff, nxt_bit, byte_ff, nxt_byte;
  logic [1:0] tar_ff, nxt_tar;
  logic cs_ff, nxt_cs, sck_ff, nxt_sck, got_ff, nxt_got;
  logic err_ff, nxt_err, tgl_ff, nxt_tgl, tick, fall, byte_end;

  function automatic logic [3:0] lanes(input espil_width_t w, input logic [3:0] d);
    if (w == ESPIL_W4) return d;
    else if (w == ESPIL_W2) return {2'h0, d[3:2]};
    else return {3'h0, d[3]};
  endfunction

  always_comb
  begin
    bpc = (fr_ff.width == ESPIL_W4) ? 4'h4 : (fr_ff.width == ESPIL_W2) ? 4'h2 : 4'h1;
    tick = (half_ff == fr_ff.half - 4'h1);
    fall = tick && sck_ff;
    byte_end = (({1'b0, bit_ff} + bpc) == 4'h8);
    nxt_st = st_ff;
    nxt_fr = fr_ff;
    nxt_sh = sh_ff;
    nxt_rx = rx_ff;
    nxt_wait = wait_ff;
    nxt_half = (st_ff == ESPIL_IDLE || tick) ? 4'h0 : half_ff + 4'h1;
    nxt_io = io_ff;
    nxt_oe = oe_ff;
    nxt_bit = fall ? 3'(bit_ff + bpc[2:0]) : bit_ff;
    nxt_byte = byte_ff;
    nxt_tar = tar_ff;
    nxt_cs = cs_ff;
    nxt_sck = (tick && st_ff != ESPIL_IDLE && st_ff != ESPIL_END) ? !sck_ff : sck_ff;
    nxt_got = got_ff;
    nxt_err = err_ff;
    nxt_tgl = tgl_ff;
    if (fr_ff.width == ESPIL_W4) nxt_rxb = {rxb_ff[3:0], io_i};
    else if (fr_ff.width == ESPIL_W2) nxt_rxb = {rxb_ff[5:0], io_i[1:0]};
    else nxt_rxb = {rxb_ff[6:0], io_i[1]};
    if (!(fall && st_ff == ESPIL_RSP)) nxt_rxb = rxb_ff;
    case (st_ff)
      ESPIL_IDLE:
      begin
        nxt_sck = 1'b0;
        nxt_cs = 1'b1;
        nxt_bit = 3'h0;
        if (start)
        begin
          nxt_fr = frame;
          nxt_sh = frame.tx_data;
          nxt_rx = 64'h0;
          nxt_wait = 8'h0;
          nxt_byte = 3'h0;
          nxt_got = 1'b0;
          nxt_err = 1'b0;
          nxt_io = lanes(frame.width, frame.tx_data[63:60]);
          nxt_oe = (frame.width == ESPIL_W4) ? OE_N_W4 :
            (frame.width == ESPIL_W2) ? OE_N_W2 : OE_N_W1;
          nxt_cs = 1'b0;
          nxt_st = ESPIL_CMD;
        end
      end
      ESPIL_CMD:
        if (fall)
        begin
          nxt_sh = sh_ff << bpc;
          if (byte_end && byte_ff == fr_ff.tx_last)
          begin
            nxt_oe = OE_N_OFF;
            nxt_tar = 2'h0;
            nxt_st = ESPIL_TAR;
          end
          else
          begin
            nxt_io = lanes(fr_ff.width, nxt_sh[63:60]);
            if (byte_end) nxt_byte = byte_ff + 3'h1;
          end
        end
      ESPIL_TAR:
        if (fall)
        begin
          nxt_tar = tar_ff + 2'h1;
          nxt_bit = 3'h0;
          nxt_byte = 3'h0;
          if (tar_ff == TAR_CYC - 2'h1) nxt_st = ESPIL_RSP;
        end
      ESPIL_RSP:
        if (fall && byte_end)
        begin
          if (!got_ff && nxt_rxb == RSP_WAIT)
          begin
            if (wait_ff == fr_ff.wait_lim)
            begin
              nxt_err = 1'b1;
              nxt_st = ESPIL_END;
            end
            else nxt_wait = wait_ff + 8'h1;
          end
          else
          begin
            nxt_got = 1'b1;
            nxt_rx = {rx_ff[55:0], nxt_rxb};
            if (byte_ff == fr_ff.rx_last) nxt_st = ESPIL_END;
            else nxt_byte = byte_ff + 3'h1;
          end
        end
      default:
      begin
        nxt_cs = 1'b1;
        nxt_tgl = !tgl_ff;
        nxt_st = ESPIL_IDLE;
      end
    endcase
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= ESPIL_IDLE;
      fr_ff <= '0;
      sh_ff <= 64'h0;
      rx_ff <= 64'h0;
      rxb_ff <= 8'h0;
      wait_ff <= 8'h0;
      half_ff <= 4'h0;
      io_ff <= 4'h0;
      oe_ff <= OE_N_OFF;
      bit_ff <= 3'h0;
      byte_ff <= 3'h0;
      tar_ff <= 2'h0;
      cs_ff <= 1'b1;
      sck_ff <= 1'b0;
      got_ff <= 1'b0;
      err_ff <= 1'b0;
      tgl_ff <= 1'b0;
    end
    else if (run)
    begin
      st_ff <= nxt_st;
      fr_ff <= nxt_fr;
      sh_ff <= nxt_sh;
      rx_ff <= nxt_rx;
      rxb_ff <= nxt_rxb;
      wait_ff <= nxt_wait;
      half_ff <= nxt_half;
      io_ff <= nxt_io;
      oe_ff <= nxt_oe;
      bit_ff <= nxt_bit;
      byte_ff <= nxt_byte;
      tar_ff <= nxt_tar;
      cs_ff <= nxt_cs;
      sck_ff <= nxt_sck;
      got_ff <= nxt_got;
      err_ff <= nxt_err;
      tgl_ff <= nxt_tgl;
    end
  end

  assign cs_n = cs_ff;
  assign sck = sck_ff;
  assign io_o = io_ff;
  assign io_oe_n = oe_ff;
  assign done_tgl = tgl_ff;
  assign rsp = '{rx_data: rx_ff, wait_err: err_ff};

  AST_CS_SCK_LOW: assert property (@(posedge link_clk) disable iff (sys_rst)
    $fell(cs_ff) |-> !sck_ff) else $error("Clock high at select");
  AST_OUT_ON_FALL: assert property (@(posedge link_clk) disable iff (sys_rst)
    (!cs_ff && $past(!cs_ff) && $changed(io_ff)) |-> $fell(sck_ff))
    else $error("Output changed off a falling edge");
  AST_SCK_IN_FRAME: assert property (@(posedge link_clk) disable iff (sys_rst)
    sck_ff |-> !cs_ff) else $error("Clock toggles outside frame");
  AST_WHOLE_BYTES: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(cs_ff) |-> $past(bit_ff) == 3'h0) else $error("Frame ended mid byte");
  AST_WAIT_BOUND: assert property (@(posedge link_clk) disable iff (sys_rst)
    (st_ff != ESPIL_IDLE) |-> wait_ff <= fr_ff.wait_lim) else $error("Wait count over limit");
  AST_TAR_RELEASE: assert property (@(posedge link_clk) disable iff (sys_rst)
    (st_ff == ESPIL_TAR || st_ff == ESPIL_RSP) |-> oe_ff == OE_N_OFF)
    else $error("Data driven after command");
endmodule // espil_ser

// ===== bench/espil_tgt.sv
// Behavioural link target answering the initiator
`timescale 1ns/100ps
module espil_tgt (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_o,
  input wire logic [3:0] oe_n,
  input wire logic [2:0] bpc,
  input wire logic [7:0] n_wait,
  input wire logic [63:0] rsp_d,
  output logic [3:0] io_i,
  output logic [63:0] cmd,
  output int ncmd
);
  import espil_pkg::*;
  logic [127:0] s;
  int f;
  initial io_i = 4'h5;
  always @(negedge cs_n)
  begin
    s = {rsp_d, 64'h0};
    repeat (n_wait) s = {RSP_WAIT, s[127:8]};
    cmd = 64'h0;
    ncmd = 0;
    f = 0;
  end
  always @(posedge sck)
    if (!oe_n[0])
    begin
      cmd = (cmd << bpc) | 64'(io_o & ((4'h1 << bpc) - 4'h1));
      ncmd++;
    end
  always @(negedge sck)
  begin
    f++;
    io_i = ~io_i;
    if (f >= ncmd + 2)
    begin
      if (bpc == 3'h1)
        io_i[1] = s[127];
      else if (bpc == 3'h2)
        io_i[1:0] = s[127:126];
      else
        io_i = s[127:124];
      s = s << bpc;
    end
  end
  // Released lines must not keep a stale value
  always @(posedge cs_n) io_i = ~io_i;
endmodule // espil_tgt

// ===== bench/tb.sv
// Self-checking bench for the link initiator
`timescale 1ns/100ps
module tb;
  import espil_pkg::*;
  logic clock, link_clk, sys_rst, clk_en, strap_en_pin, req_valid, rsp_crc_bad;
  logic peci_req, low_power_idle_state, cpu_data_valid, rtc_req, req_ready, rsp_valid;
  logic rsp_pm_valid, rsp_se_valid, sleep, peci_pin_en, peci_link_en, cpu_wake;
  logic peci_rsp_ok, rtc_tx_valid, espi_cs_n, espi_sck;
  logic [1:0] initiator_flash_sharing;
  logic [2:0] bpc;
  logic [3:0] espi_io_o, espi_io_oe_n, espi_io_i;
  logic [7:0] wait_limit, n_wait;
  logic [63:0] rtc_now, rtc_tx_data, rsp_d, cmd;
  int ncmd, lk, lk0, per, num_errors, num_checks;
  espil_strap_t strap;
  espil_req_t req;
  espil_rsp_t rsp;
  espil_chan_t rsp_chan;
  espil_link espil_link_inst (.clock, .sys_rst, .clk_en, .link_clk, .strap_en_pin, .strap,
    .wait_limit, .req_valid, .req, .req_ready, .rsp_valid, .rsp, .rsp_chan, .rsp_pm_valid,
    .rsp_se_valid, .rsp_crc_bad, .sleep, .initiator_flash_sharing, .peci_pin_en,
    .peci_link_en, .peci_req, .low_power_idle_state, .cpu_data_valid, .cpu_wake,
    .peci_rsp_ok, .rtc_req, .rtc_now, .rtc_tx_valid, .rtc_tx_data, .espi_cs_n, .espi_sck,
    .espi_io_o, .espi_io_oe_n, .espi_io_i);
  espil_tgt espil_tgt_inst (.sck(espi_sck), .cs_n(espi_cs_n), .io_o(espi_io_o),
    .oe_n(espi_io_oe_n), .bpc, .n_wait, .rsp_d, .io_i(espi_io_i), .cmd, .ncmd);
  task chk(input logic [63:0] g, e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wt(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 6000)
    begin
      tick(1);
      n++;
    end
    chk(s, 1);
  endtask
  task automatic xfer(input espil_chan_t ch, input logic se, cfg, input logic [2:0] tl, rl,
    input logic [63:0] td, d, input logic [7:0] nw);
    wt(req_ready);
    rsp_d = d;
    n_wait = nw;
    req = '{ch, se, cfg, tl, rl, td};
    req_valid = 1;
    tick(1);
    req_valid = 0;
    wt(rsp_valid);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    link_clk = 0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  always @(posedge link_clk) lk++;
  always @(posedge espi_sck)
  begin
    per = lk - lk0;
    lk0 = lk;
  end
  always @(negedge espi_cs_n) #1 chk(espi_sck, 0);
  initial
  begin
    #500000;
    num_errors++;
    give_verdict;
  end
  initial
  begin
    {sys_rst, clk_en, strap_en_pin, req_valid, rsp_crc_bad} = 5'h1c;
    {peci_req, low_power_idle_state, cpu_data_valid, rtc_req} = 4'h0;
    strap = '{FREQ_F50, 2'h2, 1'b0, ESPIL_W4};
    {wait_limit, n_wait, bpc, req, rsp_d} = '0;
    rtc_now = 64'h0123456789abcdef;
    wait_limit = 8'h4;
    bpc = 3'h1;
    tick(2);
    chk(sleep, 1);
    sys_rst = 0;
    xfer(ESPIL_CH_PERIPH, 0, 0, 1, 1, {16'ha55a, 48'h0}, {16'h1234, 48'h0}, 0);
    chk(cmd, 64'ha55a);
    chk(rsp.rx_data[15:0], 16'h1234);
    chk(per, 2 * HALF_F20);
    chk(initiator_flash_sharing, 2);
    chk({peci_pin_en, peci_link_en}, 2);
    xfer(ESPIL_CH_VWIRE, 0, 0, 0, 0, {8'h3c, 56'h0}, {8'hc3, 56'h0}, 3);
    chk(rsp.rx_data[7:0], 8'hc3);
    chk(rsp.wait_err, 0);
    chk(rsp_chan, ESPIL_CH_VWIRE);
    wait_limit = 8'h2;
    xfer(ESPIL_CH_FLASH, 0, 0, 0, 0, {8'h3c, 56'h0}, {8'hc3, 56'h0}, 3);
    chk(rsp.wait_err, 1);
    wait_limit = 8'h4;
    xfer(ESPIL_CH_OOB, 1, 0, 0, 0, 0, {8'h77, 56'h0}, 0);
    chk({rsp_se_valid, rsp_pm_valid}, 2);
    xfer(ESPIL_CH_OOB, 0, 0, 0, 0, 0, {8'h77, 56'h0}, 0);
    chk({rsp_se_valid, rsp_pm_valid}, 1);
    xfer(ESPIL_CH_PERIPH, 0, 1, 0, 0, {8'h21, 56'h0}, {8'h08, 56'h0}, 0);
    bpc = 3'h4;
    xfer(ESPIL_CH_PERIPH, 0, 0, 1, 3, {16'hbeef, 48'h0}, {32'h89abcdef, 32'h0}, 0);
    chk(rsp.rx_data[31:0], 32'h89abcdef);
    chk(cmd, 64'hbeef);
    chk(per, 2 * HALF_F50);
    xfer(ESPIL_CH_PERIPH, 0, 1, 0, 0, {8'h21, 56'h0}, {8'h08, 56'h0}, 0);
    rsp_crc_bad = 1;
    bpc = 3'h1;
    tick(1);
    rsp_crc_bad = 0;
    tick(20);
    chk(req_ready, 0);
    wt(req_ready);
    chk(cmd, CMD_INBAND_RST);
    chk(ncmd, 8);
    xfer(ESPIL_CH_PERIPH, 0, 0, 0, 0, {8'h5a, 56'h0}, {8'ha5, 56'h0}, 0);
    chk(rsp.rx_data[7:0], 8'ha5);
    chk(per, 2 * HALF_F20);
    // Dual width at the third speed, then single at the second
    strap.freq_sel = FREQ_F33;
    strap.max_width = ESPIL_W2;
    xfer(ESPIL_CH_PERIPH, 0, 1, 0, 0, {8'h21, 56'h0}, {8'h08, 56'h0}, 0);
    bpc = 3'h2;
    xfer(ESPIL_CH_PERIPH, 0, 0, 0, 1, {8'h96, 56'h0}, {16'h4321, 48'h0}, 0);
    chk(cmd, 64'h96);
    chk(rsp.rx_data[15:0], 16'h4321);
    chk(per, 2 * HALF_F33);
    strap.freq_sel = FREQ_F25;
    strap.max_width = ESPIL_W1;
    xfer(ESPIL_CH_PERIPH, 0, 1, 0, 0, {8'h21, 56'h0}, {8'h08, 56'h0}, 0);
    bpc = 3'h1;
    xfer(ESPIL_CH_VWIRE, 0, 0, 0, 0, {8'h69, 56'h0}, {8'h5e, 56'h0}, 1);
    chk(rsp.rx_data[7:0], 8'h5e);
    chk(per, 2 * HALF_F25);
    rtc_req = 1;
    tick(1);
    rtc_req = 0;
    wt(rtc_tx_valid);
    chk(rtc_tx_data, 64'h0123456789abcdef);
    strap.peci_over_link = 1;
    low_power_idle_state = 1;
    tick(4);
    chk({peci_pin_en, peci_link_en}, 1);
    peci_req = 1;
    tick(1);
    peci_req = 0;
    tick(4);
    chk(cpu_wake, 1);
    chk(peci_rsp_ok, 0);
    cpu_data_valid = 1;
    wt(peci_rsp_ok);
    // Frozen state must not capture a request
    clk_en = 0;
    rtc_req = 1;
    tick(3);
    chk(rtc_tx_valid, 0);
    rtc_req = 0;
    clk_en = 1;
    tick(2);
    chk(rtc_tx_valid, 0);
    strap_en_pin = 0;
    tick(6);
    chk(sleep, 1);
    chk(req_ready, 0);
    give_verdict;
  end
endmodule // tb
